/* shared/rtc_pkg.sv */
package rtc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] SEC_OFS = 16'h00E0;
  localparam logic [15:0] MIN_OFS = 16'h00E1;
  localparam logic [15:0] HRS_OFS = 16'h00E2;
  localparam logic [15:0] DOW_OFS = 16'h00E3;
  localparam logic [15:0] DOM_OFS = 16'h00E4;
  localparam logic [15:0] MON_OFS = 16'h00E5;
  localparam logic [15:0] YR_OFS = 16'h00E6;
  localparam logic [15:0] CEN_OFS = 16'h00E7;
  localparam logic [15:0] ASEC_OFS = 16'h00E8;
  localparam logic [15:0] AMIN_OFS = 16'h00E9;
  localparam logic [15:0] AHRS_OFS = 16'h00EA;
  localparam logic [15:0] ADOW_OFS = 16'h00EB;
  localparam logic [15:0] AEN_OFS = 16'h00EC;
  localparam logic [15:0] CTRL_OFS = 16'h00ED;

  // ************************************************************
  // Control and alarm-enable fields
  // ************************************************************
  localparam int CTRL_UNLOCK = 0;
  localparam int CTRL_FREQ60 = 1;
  localparam int CTRL_LINESRC = 2;
  localparam int CTRL_BCD = 3;
  localparam int CTRL_INTEN = 4;
  localparam int CTRL_FLAG = 7;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [3:0] AEN_RESET = 4'h0;
  localparam logic [7:0] DOW_MASK = 8'h0F;

  // ************************************************************
  // Count fields and limits (binary values)
  // ************************************************************
  localparam int CNT_NUM = 8;
  localparam int F_SEC = 0;
  localparam int F_MIN = 1;
  localparam int F_HRS = 2;
  localparam int F_DOW = 3;
  localparam int F_DOM = 4;
  localparam int F_MON = 5;
  localparam int F_YR = 6;
  localparam int F_CEN = 7;
  localparam logic [7:0] SEC_MAX = 8'h3B;
  localparam logic [7:0] HRS_MAX = 8'h17;
  localparam logic [7:0] DOW_MIN = 8'h01;
  localparam logic [7:0] DOW_MAX = 8'h07;
  localparam logic [7:0] DOM_MIN = 8'h01;
  localparam logic [7:0] DOM_MAX = 8'h1F;
  localparam logic [7:0] DOM_30 = 8'h1E;
  localparam logic [7:0] DOM_FEB = 8'h1C;
  localparam logic [7:0] DOM_LEAP = 8'h1D;
  localparam logic [7:0] MON_MIN = 8'h01;
  localparam logic [7:0] MON_MAX = 8'h0C;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h0B;
  localparam logic [7:0] YR_MAX = 8'h63;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] DEC_BASE = 8'h0A;

  // ************************************************************
  // Tick sources
  // ************************************************************
  localparam int XTAL_HZ = 32768;
  localparam int LINE50_HZ = 50;
  localparam int LINE60_HZ = 60;

  // Host I/O cycle as seen at the device pins
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } io_req_s;

  typedef enum logic {CMP_IDLE, CMP_RUN} cmp_state_e;

  // Packed two-digit decimal to binary
  function automatic logic [7:0] bcd2bin(input logic [7:0] v);
    logic [7:0] t;
    t = {4'h0, v[7:4]};
    return 8'((t << 3) + (t << 1) + {4'h0, v[3:0]});
  endfunction : bcd2bin

endpackage : rtc_pkg

/* core/field_step.sv */
`timescale 1ns/1ps
// Next value of one count field in binary or decimal-digit form
module field_step
  import rtc_pkg::*;
(
  input wire logic [7:0] val,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  input wire logic bcd,
  output logic [7:0] nxt,
  output logic wrap
);

  logic [7:0] bin;
  logic [7:0] inc;

  // ************************************************************
  // Wrap at the limit, otherwise step by one
  // ************************************************************
  always_comb begin
    bin = bcd ? bcd2bin(val) : val;
    wrap = (bin >= hi);
    inc = wrap ? lo : 8'(bin + 8'h01);
    // Back to two digits; division by ten is a small constant divider
    if (bcd) begin
      nxt = {4'(inc / DEC_BASE), 4'(inc % DEC_BASE)};
    end else begin
      nxt = inc;
    end
  end

endmodule : field_step

/* core/tick_divider.sv */
`timescale 1ns/1ps
// Seconds prescaler fed by the crystal or the line clock
module tick_divider
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = XTAL_HZ,
  parameter int CW = 16
)(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic line_src,
  input wire logic freq60,
  input wire logic clear,
  input wire logic xtal_in,
  input wire logic line_in,
  output logic tick
);

  logic src_prev_ff;
  logic [CW-1:0] cnt_ff;
  logic src_now;
  logic src_rise;
  logic [CW-1:0] last;

  assign src_now = line_src ? line_in : xtal_in;
  assign src_rise = src_now & ~src_prev_ff;
  assign last = line_src ? CW'(freq60 ? LINE60_HZ - 1 : LINE50_HZ - 1)
                         : CW'(XTAL_DIV - 1);

  // ************************************************************
  // Count source edges; clear restarts from a fresh phase
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_ff <= 1'b0;
      cnt_ff <= '0;
      tick <= 1'b0;
    end else begin
      src_prev_ff <= src_now;
      tick <= 1'b0;
      if (clear) begin
        cnt_ff <= '0;
      end else if (src_rise) begin
        if (cnt_ff >= last) begin
          cnt_ff <= '0;
          tick <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

endmodule : tick_divider

/* core/calendar_time_counter.sv */
// Function
// (RQ1) 24-hour clock with full calendar fields
// (RQ2) One bit selects binary or decimal digits
// (RQ3) Month lengths and leap years only decimal
// (RQ4) Alarm when all enabled set-points match
// (RQ5) Alarm sets flag; interrupt only if enabled
// (RQ6) Control read clears flag and interrupt
// (RQ7) Alarm registers writable regardless of lock
// (RQ8) Compare alarms each time count advances
// (RQ9) Writing unlock zero forces a comparison
// (RQ10) Tick from crystal or 50/60 Hz line
// (RQ11) Control write resets the prescaler
// (RQ12) Alarm enables cleared after power-up reset
// (RQ13) Software unlocks, sets time, alarms, relocks
// (RQ14) Relocking restarts divider from fresh phase
// (RQ15) Unlocked: counting stops, counts writable
// (RQ16) Locked: counting runs, count writes ignored
// (RQ17) Reset returns to locked state
// (RQ18) Reset leaves time counts unchanged
// (RQ19) Seconds 00h-3Bh, tens digit 0-5
// (RQ20) Minutes 00h-3Bh, tens digit 0-5
// (RQ21) Hours 00h-17h, tens digit 0-2
// (RQ22) Registers decoded from host I/O cycles
// (RQ23) Weekday 01h-07h, upper nibble zero
// (RQ24) Day of month 01h-1Fh by month
// (RQ25) Month 01h-0Ch after month end
// (RQ26) Year 00h-63h carrying into century
// (RQ27) Fields wrap and carry in format
`timescale 1ns/1ps
module calendar_time_counter
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = XTAL_HZ
)(
  input wire logic clock,
  input wire logic rst_n,
  input wire io_req_s io_req,
  input wire logic crystal_output_pin,
  input wire logic line_clk_in,
  output logic [7:0] rd_data_ff,
  output logic irq_ff
);

  // ************************************************************
  // State
  // ************************************************************
  // Kept through a system reset; the host must load them once
  logic [7:0] cnt_ff [CNT_NUM];
  logic [7:0] alarm_ff [4];
  // Cleared by a system reset
  logic [3:0] alarm_en_ff;
  // Control fields
  logic unlock_ff;
  logic freq60_ff;
  logic line_src_ff;
  logic bcd_en_ff;
  logic int_en_ff;
  logic flag_ff;
  // Alarm comparison sequencer
  cmp_state_e cmp_ff;

  // One-second pulse from the prescaler
  logic tick;
  // Decoded host cycles
  logic ctrl_wr;
  logic ctrl_rd;
  logic cnt_wr;
  logic alarm_wr;
  logic [2:0] cnt_idx;
  logic [1:0] alarm_idx;
  // Per-field limits and steps
  logic [7:0] lo [CNT_NUM];
  logic [7:0] hi [CNT_NUM];
  logic [7:0] step [CNT_NUM];
  logic wrap [CNT_NUM];
  logic adv [CNT_NUM];
  // Month length
  logic [7:0] mon_bin;
  logic [7:0] yr_bin;
  logic leap;
  logic [7:0] dom_last;
  // Alarm match
  logic [3:0] match;
  logic hit;
  // Read path
  logic [7:0] nxt_rd_data;
  logic [7:0] ctrl_view;

  // ************************************************************
  // Address decode of host I/O cycles
  // ************************************************************
  // Every register sits on one byte address; no wait states needed
  // The lock is checked where the counts are stored, so a locked
  // count write still decodes but is dropped there silently
  assign ctrl_wr = io_req.wr && (io_req.addr == CTRL_OFS); // [RQ22]
  assign ctrl_rd = io_req.rd && (io_req.addr == CTRL_OFS); // [RQ22]
  assign cnt_wr = io_req.wr && (io_req.addr >= SEC_OFS) &&
                  (io_req.addr <= CEN_OFS);
  assign alarm_wr = io_req.wr && (io_req.addr >= ASEC_OFS) &&
                    (io_req.addr <= ADOW_OFS);
  assign cnt_idx = 3'(io_req.addr - SEC_OFS);
  assign alarm_idx = 2'(io_req.addr - ASEC_OFS);

  // ************************************************************
  // Seconds prescaler
  // ************************************************************
  // Held clear while unlocked so relocking starts a full second
  // Any control write clears it too, so a change of source or line
  // rate never yields a short first second
  tick_divider #(
    .XTAL_DIV(XTAL_DIV)
  ) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .line_src(line_src_ff), // [RQ10]
    .freq60(freq60_ff), // [RQ10]
    .clear(ctrl_wr || unlock_ff), // [RQ11] [RQ14]
    .xtal_in(crystal_output_pin),
    .line_in(line_clk_in),
    .tick(tick)
  );

  // ************************************************************
  // Calendar limits
  // ************************************************************
  // Binary form has no month table: every month runs to 1Fh
  // Leap years are every fourth year; the century is not consulted,
  // so a century year that is not leap is still taken as one
  always_comb begin
    mon_bin = bcd2bin(cnt_ff[F_MON]);
    yr_bin = bcd2bin(cnt_ff[F_YR]);
    leap = (yr_bin[1:0] == 2'b00);
    dom_last = DOM_MAX;
    if (bcd_en_ff) begin // [RQ3]
      if (mon_bin == MON_FEB) begin
        dom_last = leap ? DOM_LEAP : DOM_FEB;
      end else if (mon_bin == MON_APR || mon_bin == MON_JUN ||
                   mon_bin == MON_SEP || mon_bin == MON_NOV) begin
        dom_last = DOM_30;
      end
    end
  end

  // Per-field range, all in binary values
  // Unnamed fields take the year range, which the century shares
  always_comb begin
    for (int i = 0; i < CNT_NUM; i++) begin
      lo[i] = ZERO8;
      hi[i] = YR_MAX; // [RQ26]
    end
    hi[F_SEC] = SEC_MAX; // [RQ19]
    hi[F_MIN] = SEC_MAX; // [RQ20]
    hi[F_HRS] = HRS_MAX; // [RQ1] [RQ21]
    lo[F_DOW] = DOW_MIN; // [RQ23]
    hi[F_DOW] = DOW_MAX; // [RQ23]
    lo[F_DOM] = DOM_MIN; // [RQ24]
    hi[F_DOM] = dom_last; // [RQ24]
    lo[F_MON] = MON_MIN; // [RQ25]
    hi[F_MON] = MON_MAX; // [RQ25]
  end

  // ************************************************************
  // Field steppers and carry chain
  // ************************************************************
  // One stepper per field; all share the format select
  for (genvar g = 0; g < CNT_NUM; g++) begin : g_field
    field_step u_step (
      .val(cnt_ff[g]),
      .lo(lo[g]),
      .hi(hi[g]),
      .bcd(bcd_en_ff), // [RQ2]
      .nxt(step[g]),
      .wrap(wrap[g])
    );
  end

  // Weekday and day of month both step on the hours carry
  // Each stage needs the whole carry product, so one tick moves
  // every field by at most one step
  always_comb begin
    adv[F_SEC] = tick && !unlock_ff; // [RQ16]
    adv[F_MIN] = adv[F_SEC] && wrap[F_SEC]; // [RQ27]
    adv[F_HRS] = adv[F_MIN] && wrap[F_MIN]; // [RQ27]
    adv[F_DOW] = adv[F_HRS] && wrap[F_HRS]; // [RQ27]
    adv[F_DOM] = adv[F_HRS] && wrap[F_HRS]; // [RQ27]
    adv[F_MON] = adv[F_DOM] && wrap[F_DOM]; // [RQ25]
    adv[F_YR] = adv[F_MON] && wrap[F_MON]; // [RQ27]
    adv[F_CEN] = adv[F_YR] && wrap[F_YR]; // [RQ26]
  end

  // ************************************************************
  // Count registers
  // ************************************************************
  // No reset: the time survives a system reset untouched
  // Steps need the lock closed and writes need it open, so the two
  // never meet on one field in the same cycle
  always_ff @(posedge clock) begin // [RQ18]
    for (int i = 0; i < CNT_NUM; i++) begin
      if (adv[i]) begin
        cnt_ff[i] <= step[i]; // [RQ1] [RQ8]
      end
    end
    if (cnt_wr && unlock_ff) begin // [RQ15] [RQ16]
      // The weekday keeps only its low nibble
      if (int'(cnt_idx) == F_DOW) begin
        cnt_ff[cnt_idx] <= io_req.data & DOW_MASK; // [RQ23]
      end else begin
        cnt_ff[cnt_idx] <= io_req.data;
      end
    end
  end

  // ************************************************************
  // Alarm set-points
  // ************************************************************
  // Set-points keep their value over reset like the counts
  // No lock check: the alarm may be retuned while the time runs
  always_ff @(posedge clock) begin
    if (alarm_wr) begin
      alarm_ff[alarm_idx] <= io_req.data; // [RQ7]
    end
  end

  // Alarm enables, cleared by the power-up reset
  // Any system reset is taken as the power-up case here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_en_ff <= AEN_RESET; // [RQ12]
    end else if (io_req.wr && io_req.addr == AEN_OFS) begin
      alarm_en_ff <= io_req.data[3:0]; // [RQ7]
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  // The flag bit is read only; the alarm logic below owns it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {int_en_ff, bcd_en_ff, line_src_ff, freq60_ff, unlock_ff} <=
        CTRL_RESET; // [RQ17]
    end else if (ctrl_wr) begin
      unlock_ff <= io_req.data[CTRL_UNLOCK]; // [RQ15] [RQ16]
      freq60_ff <= io_req.data[CTRL_FREQ60]; // [RQ10]
      line_src_ff <= io_req.data[CTRL_LINESRC]; // [RQ10]
      bcd_en_ff <= io_req.data[CTRL_BCD]; // [RQ2]
      int_en_ff <= io_req.data[CTRL_INTEN]; // [RQ5]
    end
  end

  // ************************************************************
  // Alarm comparison
  // ************************************************************
  // Compare one cycle after the count steps, or on any control write with unlock zero
  // The extra cycle lets the stepped count reach the comparators, so
  // a match is judged on the new time and not the old one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_ff <= CMP_IDLE;
    end else begin
      case (cmp_ff)
        CMP_IDLE: begin
          if (adv[F_SEC] ||
              (ctrl_wr && !io_req.data[CTRL_UNLOCK])) begin // [RQ8] [RQ9]
            cmp_ff <= CMP_RUN;
          end
        end
        // Judge the match in this one cycle, then idle
        CMP_RUN: begin
          cmp_ff <= CMP_IDLE;
        end
        default: begin
          cmp_ff <= CMP_IDLE;
        end
      endcase
    end
  end

  // Disabled fields always match; with none enabled nothing fires
  // Fields compare as raw bytes, so set-points use the count format
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = !alarm_en_ff[i] || (alarm_ff[i] == cnt_ff[i]);
    end
    hit = (cmp_ff == CMP_RUN) && (&match) && (|alarm_en_ff); // [RQ4]
  end

  // Flag and request; a new hit wins over a clearing read
  // The request copies the enable seen at the hit; a later enable
  // change neither raises nor drops a pending request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (hit) begin
      flag_ff <= 1'b1; // [RQ5]
      irq_ff <= int_en_ff; // [RQ5]
    end else if (ctrl_rd) begin
      flag_ff <= 1'b0; // [RQ6]
      irq_ff <= 1'b0; // [RQ6]
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Control view built by field position; unused bits read zero
  always_comb begin
    ctrl_view = ZERO8;
    ctrl_view[CTRL_UNLOCK] = unlock_ff;
    ctrl_view[CTRL_FREQ60] = freq60_ff;
    ctrl_view[CTRL_LINESRC] = line_src_ff;
    ctrl_view[CTRL_BCD] = bcd_en_ff;
    ctrl_view[CTRL_INTEN] = int_en_ff;
    ctrl_view[CTRL_FLAG] = flag_ff; // [RQ5]
  end

  // Unmapped addresses read as zero
  // Only the control address has a read side effect, handled above
  always_comb begin
    nxt_rd_data = ZERO8;
    if (io_req.addr >= SEC_OFS && io_req.addr <= CEN_OFS) begin
      nxt_rd_data = cnt_ff[cnt_idx];
    end else if (io_req.addr >= ASEC_OFS && io_req.addr <= ADOW_OFS) begin
      nxt_rd_data = alarm_ff[alarm_idx];
    end else if (io_req.addr == AEN_OFS) begin
      nxt_rd_data = {4'h0, alarm_en_ff};
    end else if (io_req.addr == CTRL_OFS) begin
      nxt_rd_data = ctrl_view;
    end
  end

  // Read data is held until the next read cycle
  // Holding it lets a slow host pick the byte up late
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= ZERO8;
    end else if (io_req.rd) begin
      rd_data_ff <= nxt_rd_data; // [RQ22]
    end
  end

endmodule : calendar_time_counter

/* verif/rtc_checker_sva.sv */
`timescale 1ns/1ps
// ************************************************************
// Port-level checks of the counter
// ************************************************************
module rtc_checker
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = XTAL_HZ
)(
  input wire logic clock,
  input wire logic rst_n,
  input wire io_req_s io_req,
  input wire logic crystal_output_pin,
  input wire logic line_clk_in,
  input wire logic [7:0] rd_data_ff,
  input wire logic irq_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Decoded host reads; only reads move the read register
  logic rd_ctrl;
  logic rd_map;
  assign rd_ctrl = io_req.rd && io_req.addr == CTRL_OFS;
  assign rd_map = io_req.addr inside {[SEC_OFS:CTRL_OFS]};

  property p_rel_quiet;
    $rose(rst_n) |-> !irq_ff && rd_data_ff == 8'h00;
  endproperty
  a_rel_quiet: assert property (p_rel_quiet)
    else $error("outputs not clear after reset");
  property p_irq_hold;
    irq_ff && !rd_ctrl |=> irq_ff;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without control read");
  property p_irq_drop;
    $fell(irq_ff) |-> $past(rd_ctrl);
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("interrupt cleared by something else");
  property p_irq_flag;
    rd_ctrl && irq_ff |=> rd_data_ff[7] && rd_data_ff[4];
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("interrupt without flag and enable");
  property p_unmapped;
    io_req.rd && !rd_map |=> rd_data_ff == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rd_hold;
    !io_req.rd |=> $stable(rd_data_ff);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  property p_dow_hi;
    io_req.rd && io_req.addr == DOW_OFS |=> rd_data_ff[7:4] == 4'h0;
  endproperty
  a_dow_hi: assert property (p_dow_hi)
    else $error("weekday upper nibble set");
  property p_sec_rng;
    io_req.rd && io_req.addr == SEC_OFS |=> rd_data_ff <= 8'h59;
  endproperty
  a_sec_rng: assert property (p_sec_rng)
    else $error("seconds out of range");
  property p_min_rng;
    io_req.rd && io_req.addr == MIN_OFS |=> rd_data_ff <= 8'h59;
  endproperty
  a_min_rng: assert property (p_min_rng)
    else $error("minutes out of range");
  property p_hrs_rng;
    io_req.rd && io_req.addr == HRS_OFS |=> rd_data_ff <= 8'h23;
  endproperty
  a_hrs_rng: assert property (p_hrs_rng)
    else $error("hours out of range");
endmodule : rtc_checker

/* verif/host_io_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Host CPU issuing single-byte I/O cycles
// ************************************************************
module host_io_model
  import rtc_pkg::*;
(
  input wire logic clock,
  output io_req_s io_req,
  input wire logic [7:0] rd_data
);
  initial io_req = '0;

  // One-cycle write strobe; released lines show inverted junk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    io_req <= '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
    @(negedge clock);
    io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
  endtask : wr

  // Data is registered on the edge that takes the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
    @(negedge clock);
    io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: 8'hFF};
    d = rd_data;
  endtask : rd
endmodule : host_io_model

/* verif/calendar_time_counter_test.sv */
`timescale 1ns/1ps
module calendar_time_counter_test
  import rtc_pkg::*;
;
  // ************************************************************
  // Stimulus and reference state
  // ************************************************************
  localparam int DIV = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic xtal = 1'b0;
  logic line = 1'b0;
  io_req_s io_req;
  logic [7:0] rd_data_ff;
  logic irq_ff;
  logic [7:0] got;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'ha37d;
  int cnt[8];
  int lo[8] = '{0, 0, 0, 1, 1, 1, 0, 0};
  int hi[8] = '{59, 59, 23, 7, 31, 12, 99, 99};
  int t[8] = '{59, 59, 23, 0, 28, 2, 4, 0};
  bit bcd = 1'b0;

  always #20 clock = ~clock;

  calendar_time_counter #(.XTAL_DIV(DIV)) dut_u (
    .clock(clock), .rst_n(rst_n), .io_req(io_req),
    .crystal_output_pin(xtal), .line_clk_in(line),
    .rd_data_ff(rd_data_ff), .irq_ff(irq_ff));
  host_io_model host_u (
    .clock(clock), .io_req(io_req), .rd_data(rd_data_ff));

  // ************************************************************
  // Reference model, kept in plain integers
  // ************************************************************
  function automatic int enc(int v);
    return bcd ? (v / 10) * 16 + v % 10 : v;
  endfunction : enc
  // Binary mode runs every month to 31; only decimal knows leap years
  function automatic int last_day();
    if (!bcd) return 31;
    if (cnt[5] == 2) return (cnt[6] % 4 == 0) ? 29 : 28;
    if (cnt[5] inside {4, 6, 9, 11}) return 30;
    return 31;
  endfunction : last_day
  function automatic bit stepf(int i);
    int top;
    top = (i == 4) ? last_day() : hi[i];
    if (cnt[i] >= top) begin
      cnt[i] = lo[i];
      return 1'b1;
    end
    cnt[i]++;
    return 1'b0;
  endfunction : stepf
  // One second; weekday wraps on its own without carrying
  task automatic adv();
    if (stepf(0) && stepf(1) && stepf(2)) begin
      void'(stepf(3));
      if (stepf(4) && stepf(5) && stepf(6)) void'(stepf(7));
    end
  endtask : adv

  // ************************************************************
  // Bus and comparison helpers
  // ************************************************************
  task automatic chk(input logic [7:0] g, input int e);
    checks_done++;
    if (g !== 8'(e)) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, 8'(e));
    end
  endtask : chk
  task automatic rdchk(input logic [15:0] a, input int e);
    host_u.rd(a, got);
    chk(got, e);
  endtask : rdchk
  task automatic chkall();
    for (int i = 0; i < CNT_NUM; i++) rdchk(SEC_OFS + 16'(i), enc(cnt[i]));
  endtask : chkall
  task automatic setc(input int i, input int v);
    cnt[i] = v;
    host_u.wr(SEC_OFS + 16'(i), 8'(enc(v)));
  endtask : setc
  // Source edges spaced far beyond the two-cycle minimum
  task automatic pulses(input bit use_line, input int n);
    repeat (n) begin
      repeat (5) @(negedge clock);
      if (use_line) line = 1'b1;
      else xtal = 1'b1;
      repeat (5) @(negedge clock);
      line = 1'b0;
      xtal = 1'b0;
    end
  endtask : pulses
  task automatic final_report();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Hang guard, well above the length of the sequence below
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      final_report();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    rdchk(CTRL_OFS, 8'h00);
    rdchk(AEN_OFS, 8'h00);
    rdchk(16'h00F0, 8'h00);
    // Unlock, load every field at its maximum, read back
    host_u.wr(CTRL_OFS, 8'h01);
    foreach (cnt[i]) setc(i, hi[i]);
    chkall();
    host_u.wr(CTRL_OFS, 8'h00);
    host_u.wr(SEC_OFS, 8'($random(seed)));
    pulses(1'b0, DIV - 1);
    chkall();
    // A control write restarts the prescaler, so no second yet
    host_u.wr(CTRL_OFS, 8'h00);
    pulses(1'b0, DIV - 1);
    chkall();
    pulses(1'b0, 1);
    adv();
    chkall();
    host_u.wr(CTRL_OFS, 8'h01);
    pulses(1'b0, DIV);
    chkall();
    // Decimal end of February, leap year then plain year
    for (int k = 0; k < 2; k++) begin
      host_u.wr(CTRL_OFS, 8'h09);
      bcd = 1'b1;
      foreach (t[i]) if (i != 3 && i != 7) setc(i, t[i] + (i == 6 ? k : 0));
      host_u.wr(CTRL_OFS, 8'h08);
      pulses(1'b0, DIV);
      adv();
      chkall();
    end
    host_u.wr(CTRL_OFS, 8'h01);
    bcd = 1'b0;
    foreach (cnt[i]) setc(i, lo[i] + {$random(seed)} % (hi[i] - lo[i] + 1));
    chkall();
    // Alarm set-points written while locked
    host_u.wr(CTRL_OFS, 8'h00);
    host_u.wr(ASEC_OFS, 8'(cnt[0]));
    host_u.wr(AEN_OFS, 8'h01);
    rdchk(AEN_OFS, 8'h01);
    host_u.wr(CTRL_OFS, 8'h10);
    repeat (3) @(negedge clock);
    chk({7'h00, irq_ff}, 1);
    rdchk(CTRL_OFS, 8'h90);
    chk({7'h00, irq_ff}, 0);
    rdchk(CTRL_OFS, 8'h10);
    host_u.wr(CTRL_OFS, 8'h00);
    // Let the forced comparison finish before looking at the request
    repeat (2) @(negedge clock);
    chk({7'h00, irq_ff}, 0);
    rdchk(CTRL_OFS, 8'h80);
    host_u.wr(AMIN_OFS, 8'((cnt[1] + 1) % 60));
    host_u.wr(AEN_OFS, 8'h03);
    host_u.wr(CTRL_OFS, 8'h00);
    rdchk(CTRL_OFS, 8'h00);
    host_u.wr(AEN_OFS, 8'h01);
    host_u.wr(ASEC_OFS, 8'((cnt[0] + 1) % 60));
    host_u.wr(CTRL_OFS, 8'h10);
    repeat (2) @(negedge clock);
    chk({7'h00, irq_ff}, 0);
    pulses(1'b0, DIV);
    adv();
    chk({7'h00, irq_ff}, 1);
    rdchk(CTRL_OFS, 8'h90);
    // Line clock at 50 then 60 edges per second
    for (int k = 0; k < 2; k++) begin
      host_u.wr(CTRL_OFS, 8'(4 + 2 * k));
      pulses(1'b1, 49 + 10 * k);
      chkall();
      pulses(1'b1, 1);
      adv();
      chkall();
    end
    // Reset in mid-run keeps the time but relocks
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chkall();
    rdchk(CTRL_OFS, 8'h00);
    rdchk(AEN_OFS, 8'h00);
    final_report();
  end
endmodule : calendar_time_counter_test

bind calendar_time_counter rtc_checker #(.XTAL_DIV(XTAL_DIV)) chk_u (
  .clock(clock), .rst_n(rst_n), .io_req(io_req),
  .crystal_output_pin(crystal_output_pin), .line_clk_in(line_clk_in),
  .rd_data_ff(rd_data_ff), .irq_ff(irq_ff));
